// [src/ssrd_consts.vh]
// Purpose: shared constants of the system service request decoder
// Assumes: one 40 MHz clock, synchronous active-low reset
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef SSRD_CONSTS_VH
`define SSRD_CONSTS_VH

// clock rate and the derived length of one millisecond
`define SSRD_CLK_HZ 40000000
`define SSRD_CYC_PER_MS (`SSRD_CLK_HZ / 1000)

// service identifiers handled by this block
`define SSRD_ID_SECURE_NONVOLATILE_MEMORY_PLAIN 8'h10
`define SSRD_ID_SECURE_NONVOLATILE_MEMORY_AUTH 8'h11
`define SSRD_ID_SECURE_NONVOLATILE_MEMORY_CIPHER 8'h12
`define SSRD_ID_SIG_RAW 8'h19
`define SSRD_ID_SIG_DER 8'h1a
`define SSRD_ID_IAP_PRG_IDX 8'h42
`define SSRD_ID_IAP_PRG_ADDR 8'h43
`define SSRD_ID_IAP_VER_IDX 8'h44
`define SSRD_ID_IAP_VER_ADDR 8'h45

// signature busy times in milliseconds
`define SSRD_SIG_TYP_MS 174
`define SSRD_SIG_MAX_MS 187

// width of the millisecond counter
`define SSRD_MS_W 8

// reset values
`define SSRD_ID_RST 8'h00

`endif

// [src/ssrd_id_decode.v]
// Purpose: classify a service identifier into a service family and options
// Assumes: identifier is held stable by the caller while it is read
// Notes: purely combinational; anything not listed is unsupported
`timescale 1ns/1ps
`include "ssrd_consts.vh"

module ssrd_id_decode
(
    // identifier in
    input wire [7:0] svc_id,
    // family out, one-hot or all zero
    output reg is_secure_nonvolatile_memory,
    output reg is_sig,
    output reg is_iap,
    // options for the selected family
    output reg opt_auth,
    output reg opt_cipher,
    output reg opt_der,
    output reg opt_verify,
    output reg opt_by_addr
);

    // table lookup; reserved and out-of-scope codes fall to default
    always @*
    begin
        is_secure_nonvolatile_memory = 1'b0;
        is_sig = 1'b0;
        is_iap = 1'b0;
        opt_auth = 1'b0;
        opt_cipher = 1'b0;
        opt_der = 1'b0;
        opt_verify = 1'b0;
        opt_by_addr = 1'b0;
        case (svc_id)
            `SSRD_ID_SECURE_NONVOLATILE_MEMORY_PLAIN:
            begin
                is_secure_nonvolatile_memory = 1'b1;
            end
            `SSRD_ID_SECURE_NONVOLATILE_MEMORY_AUTH:
            begin
                is_secure_nonvolatile_memory = 1'b1;
                opt_auth = 1'b1;
            end
            `SSRD_ID_SECURE_NONVOLATILE_MEMORY_CIPHER:
            begin
                is_secure_nonvolatile_memory = 1'b1;
                opt_auth = 1'b1;
                opt_cipher = 1'b1;
            end
            `SSRD_ID_SIG_RAW:
            begin
                is_sig = 1'b1;
            end
            `SSRD_ID_SIG_DER:
            begin
                is_sig = 1'b1;
                opt_der = 1'b1;
            end
            `SSRD_ID_IAP_PRG_IDX:
            begin
                is_iap = 1'b1;
            end
            `SSRD_ID_IAP_PRG_ADDR:
            begin
                is_iap = 1'b1;
                opt_by_addr = 1'b1;
            end
            `SSRD_ID_IAP_VER_IDX:
            begin
                is_iap = 1'b1;
                opt_verify = 1'b1;
            end
            `SSRD_ID_IAP_VER_ADDR:
            begin
                is_iap = 1'b1;
                opt_verify = 1'b1;
                opt_by_addr = 1'b1;
            end
            default:
            begin
                is_secure_nonvolatile_memory = 1'b0;
            end
        endcase
    end

endmodule // ssrd_id_decode

// [src/ssrd_ms_timer.v]
// Purpose: millisecond tick divider and elapsed-millisecond counter
// Assumes: run is a level from the same clock domain
// Notes: counter saturates instead of wrapping
`timescale 1ns/1ps
`include "ssrd_consts.vh"

module ssrd_ms_timer
#(
    parameter CYC_PER_MS = `SSRD_CYC_PER_MS,
    parameter MS_W = `SSRD_MS_W
)
(
    // clock and reset
    input wire clk,
    input wire nrst,
    // control
    input wire run,
    // status
    output reg ms_tick,
    output reg [MS_W-1:0] ms_count
);

    reg [31:0] div_r;

    // divider: one-cycle tick each millisecond while running
    always @(posedge clk)
    begin
        if (!nrst || !run)
        begin
            div_r <= 32'h0;
            ms_tick <= 1'b0;
        end
        else if (div_r == CYC_PER_MS - 1)
        begin
            div_r <= 32'h0;
            ms_tick <= 1'b1;
        end
        else
        begin
            div_r <= div_r + 32'h1;
            ms_tick <= 1'b0;
        end
    end

    // elapsed milliseconds; saturation avoids a false wrap to zero
    always @(posedge clk)
    begin
        if (!nrst || !run)
            ms_count <= {MS_W{1'b0}};
        else if (ms_tick && (ms_count != {MS_W{1'b1}}))
            ms_count <= ms_count + {{(MS_W-1){1'b0}}, 1'b1};
    end

endmodule // ssrd_ms_timer

// [src/ssrd_decoder.v]
// Purpose: system service request decoder and dispatcher with busy handshake
// Assumes: requester logic runs on clk; service engines answer with done pulses
// Notes: one request at a time; signature services are capped in time
`timescale 1ns/1ps
`include "ssrd_consts.vh"

module ssrd_decoder
#(
    parameter CYC_PER_MS = `SSRD_CYC_PER_MS,
    parameter SIG_TYP_MS = `SSRD_SIG_TYP_MS,
    parameter SIG_MAX_MS = `SSRD_SIG_MAX_MS
)
(
    // clock and reset
    input wire clk,
    input wire nrst,
    // request from fabric logic
    input wire ss_req,
    input wire [7:0] ss_id,
    output reg busy,
    output reg unsupported,
    // secure_nonvolatile_memory write engine
    output reg secure_nonvolatile_memory_start,
    output reg secure_nonvolatile_memory_auth,
    output reg secure_nonvolatile_memory_cipher,
    input wire secure_nonvolatile_memory_done,
    // signature engine
    output reg sig_start,
    output reg sig_der,
    input wire sig_done,
    output reg sig_timeout,
    output reg sig_over_typ,
    // in_application_programming engine
    output reg iap_start,
    output reg iap_verify,
    output reg iap_by_addr,
    input wire iap_done
);

    // one-hot states
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_DISPATCH = 4'b0010;
    localparam [3:0] ST_WAIT = 4'b0100;
    localparam [3:0] ST_RELEASE = 4'b1000;

    // family of the service in flight
    localparam [2:0] FAM_NONE = 3'b000;
    localparam [2:0] FAM_SECURE_NONVOLATILE_MEMORY = 3'b001;
    localparam [2:0] FAM_SIG = 3'b010;
    localparam [2:0] FAM_IAP = 3'b100;

    // cut to the counter width on purpose; both limits must fit below saturation
    localparam [`SSRD_MS_W-1:0] SIG_MAX_CNT = SIG_MAX_MS[`SSRD_MS_W-1:0];
    localparam [`SSRD_MS_W-1:0] SIG_TYP_CNT = SIG_TYP_MS[`SSRD_MS_W-1:0];

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [7:0] id_r;
    reg [2:0] fam_r;
    reg req_q_r;

    wire dec_secure_nonvolatile_memory;
    wire dec_sig;
    wire dec_iap;
    wire dec_auth;
    wire dec_cipher;
    wire dec_der;
    wire dec_verify;
    wire dec_by_addr;
    wire ms_tick;
    wire [`SSRD_MS_W-1:0] ms_count;
    wire req_rise;
    wire engine_done;
    wire sig_expired;
    wire dec_any;

    // classify the latched identifier, not the live pins
    ssrd_id_decode u_dec
    (
        .svc_id(id_r),
        .is_secure_nonvolatile_memory(dec_secure_nonvolatile_memory),
        .is_sig(dec_sig),
        .is_iap(dec_iap),
        .opt_auth(dec_auth),
        .opt_cipher(dec_cipher),
        .opt_der(dec_der),
        .opt_verify(dec_verify),
        .opt_by_addr(dec_by_addr)
    );

    // elapsed time of a signature service
    ssrd_ms_timer
    #(
        .CYC_PER_MS(CYC_PER_MS),
        .MS_W(`SSRD_MS_W)
    )
    u_tmr
    (
        .clk(clk),
        .nrst(nrst),
        .run(state_r[2] && (fam_r == FAM_SIG)),
        .ms_tick(ms_tick),
        .ms_count(ms_count)
    );

    // a new request is a rising edge of the request line
    assign req_rise = ss_req && !req_q_r;
    assign dec_any = dec_secure_nonvolatile_memory || dec_sig || dec_iap;

    // completion from the engine that owns the service in flight
    assign engine_done = ((fam_r == FAM_SECURE_NONVOLATILE_MEMORY) && secure_nonvolatile_memory_done) ||
                         ((fam_r == FAM_SIG) && sig_done) ||
                         ((fam_r == FAM_IAP) && iap_done);

    // the signature cap; busy never outlasts the maximum time by more than 3 cycles
    assign sig_expired = (fam_r == FAM_SIG) && (ms_count >= SIG_MAX_CNT);

    // request edge detector, same clock so no synchroniser
    always @(posedge clk)
    begin
        if (!nrst)
            req_q_r <= 1'b0;
        else
            req_q_r <= ss_req;
    end

    // next-state logic
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (req_rise)
                    state_nxt = ST_DISPATCH;
            end
            ST_DISPATCH:
            begin
                if (dec_any)
                    state_nxt = ST_WAIT;
                else
                    state_nxt = ST_RELEASE;
            end
            ST_WAIT:
            begin
                if (engine_done || sig_expired)
                    state_nxt = ST_RELEASE;
            end
            ST_RELEASE:
            begin
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // state register
    always @(posedge clk)
    begin
        if (!nrst)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // latch the identifier at the request edge; later pin changes are
    // ignored, which guards against a requester that breaks the hold
    always @(posedge clk)
    begin
        if (!nrst)
            id_r <= `SSRD_ID_RST;
        else if (state_r[0] && req_rise)
            id_r <= ss_id;
    end

    // family of the service in flight, fixed at dispatch
    always @(posedge clk)
    begin
        if (!nrst)
            fam_r <= FAM_NONE;
        else if (state_r[1])
        begin
            if (dec_secure_nonvolatile_memory)
                fam_r <= FAM_SECURE_NONVOLATILE_MEMORY;
            else if (dec_sig)
                fam_r <= FAM_SIG;
            else if (dec_iap)
                fam_r <= FAM_IAP;
            else
                fam_r <= FAM_NONE;
        end
        else if (state_r[0])
            fam_r <= FAM_NONE;
    end

    // busy: set at the taken edge, cleared when the service ends
    always @(posedge clk)
    begin
        if (!nrst)
            busy <= 1'b0;
        else if (state_r[0] && req_rise)
            busy <= 1'b1;
        else if (state_nxt == ST_RELEASE)
            busy <= 1'b0;
    end

    // unsupported id flag, stands until the next request is taken
    always @(posedge clk)
    begin
        if (!nrst)
            unsupported <= 1'b0;
        else if (state_r[0] && req_rise)
            unsupported <= 1'b0;
        else if (state_r[1] && !dec_any)
            unsupported <= 1'b1;
    end

    // one-cycle start pulses to the engines
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            secure_nonvolatile_memory_start <= 1'b0;
            sig_start <= 1'b0;
            iap_start <= 1'b0;
        end
        else
        begin
            secure_nonvolatile_memory_start <= state_r[1] && dec_secure_nonvolatile_memory;
            sig_start <= state_r[1] && dec_sig;
            iap_start <= state_r[1] && dec_iap;
        end
    end

    // service options, held for the whole service so engines may sample late
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            secure_nonvolatile_memory_auth <= 1'b0;
            secure_nonvolatile_memory_cipher <= 1'b0;
            sig_der <= 1'b0;
            iap_verify <= 1'b0;
            iap_by_addr <= 1'b0;
        end
        else if (state_r[1])
        begin
            secure_nonvolatile_memory_auth <= dec_auth;
            secure_nonvolatile_memory_cipher <= dec_cipher;
            sig_der <= dec_der;
            iap_verify <= dec_verify;
            iap_by_addr <= dec_by_addr;
        end
    end

    // signature timing status; cleared at each new request
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            sig_timeout <= 1'b0;
            sig_over_typ <= 1'b0;
        end
        else if (state_r[0] && req_rise)
        begin
            sig_timeout <= 1'b0;
            sig_over_typ <= 1'b0;
        end
        else if (state_r[2] && (fam_r == FAM_SIG))
        begin
            if (sig_expired && !sig_done)
                sig_timeout <= 1'b1;
            if (ms_count >= SIG_TYP_CNT)
                sig_over_typ <= 1'b1;
        end
    end

endmodule // ssrd_decoder

// [test/ssrd_engine_model.sv]
// Purpose: service engines standing behind the decoder's dispatch ports
// Assumes: start pulses last one cycle; LAT cycles per service
// Notes: hang holds back the signature answer so the time cap can act
`timescale 1ns/1ps

module ssrd_engine_model
#(
    parameter LAT = 3
)
(
    // clock
    input logic clk,
    // control from the bench
    input logic hang,
    // starts from the decoder
    input logic secure_nonvolatile_memory_start,
    input logic sig_start,
    input logic iap_start,
    // completions back
    output logic secure_nonvolatile_memory_done = 1'b0,
    output logic sig_done = 1'b0,
    output logic iap_done = 1'b0
);
    logic [2:0] fam_r = 3'h0;
    logic [7:0] cnt_r = 8'h00;

    // count down from the start, then answer once for the started family
    always @(posedge clk)
    begin
        secure_nonvolatile_memory_done <= 1'b0;
        sig_done <= 1'b0;
        iap_done <= 1'b0;
        if (secure_nonvolatile_memory_start | sig_start | iap_start)
        begin
            fam_r <= {iap_start, sig_start, secure_nonvolatile_memory_start};
            cnt_r <= LAT[7:0];
        end
        else if (cnt_r != 8'h00)
        begin
            cnt_r <= cnt_r - 8'h01;
            secure_nonvolatile_memory_done <= (cnt_r == 8'h01) & fam_r[0];
            sig_done <= (cnt_r == 8'h01) & fam_r[1] & !hang;
            iap_done <= (cnt_r == 8'h01) & fam_r[2];
        end
    end
endmodule // ssrd_engine_model

// [test/ssrd_decoder_monitor.sv]
// Purpose: timing relations of the request decoder at its ports
// Assumes: one clock, synchronous active-low reset
// Notes: a request counts only from idle, two quiet edges after busy
`timescale 1ns/1ps

module ssrd_decoder_monitor
(
    // clock and reset
    input logic clk,
    input logic nrst,
    // request side
    input logic ss_req,
    input logic [7:0] ss_id,
    input logic busy,
    input logic unsupported,
    // engine side
    input logic secure_nonvolatile_memory_start,
    input logic secure_nonvolatile_memory_auth,
    input logic secure_nonvolatile_memory_cipher,
    input logic secure_nonvolatile_memory_done,
    input logic sig_start,
    input logic sig_der,
    input logic sig_done,
    input logic sig_timeout,
    input logic iap_start,
    input logic iap_verify,
    input logic iap_by_addr,
    input logic iap_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic req_r;
    logic busy_r;
    logic [7:0] id_r;
    logic [1:0] fam_r;
    // conservative: also skips the edge right after busy drops
    wire taken = ss_req && !req_r && !busy && !busy_r;
    wire sup = (ss_id >= 8'h10 && ss_id <= 8'h12) || ss_id == 8'h19 || ss_id == 8'h1a
        || (ss_id >= 8'h42 && ss_id <= 8'h45);

    // history and the family now being served
    always @(posedge clk)
    begin
        req_r <= nrst & ss_req;
        busy_r <= nrst & busy;
        if (taken)
            id_r <= ss_id;
        if (!nrst || (!busy && !secure_nonvolatile_memory_start && !sig_start && !iap_start))
            fam_r <= 2'h0;
        else if (secure_nonvolatile_memory_start | sig_start | iap_start)
            fam_r <= {iap_start | sig_start, iap_start | secure_nonvolatile_memory_start};
    end

    property p_busy;
        taken |=> busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy missing after request");
    property p_secure_nonvolatile_memory;
        taken && ss_id >= 8'h10 && ss_id <= 8'h12 |-> ##2 secure_nonvolatile_memory_start && secure_nonvolatile_memory_auth == (id_r[0] | id_r[1])
            && secure_nonvolatile_memory_cipher == id_r[1];
    endproperty
    a_secure_nonvolatile_memory: assert property (p_secure_nonvolatile_memory) else $error("secure memory dispatch wrong");
    property p_sig;
        taken && (ss_id == 8'h19 || ss_id == 8'h1a) |-> ##2 sig_start && sig_der == id_r[1];
    endproperty
    a_sig: assert property (p_sig) else $error("signature dispatch wrong");
    property p_iap;
        taken && ss_id >= 8'h42 && ss_id <= 8'h45 |-> ##2 iap_start && iap_verify == id_r[2]
            && iap_by_addr == id_r[0];
    endproperty
    a_iap: assert property (p_iap) else $error("programming dispatch wrong");
    property p_unsup;
        taken && !sup |=> busy ##1 (!busy && unsupported && !(secure_nonvolatile_memory_start | sig_start | iap_start));
    endproperty
    a_unsup: assert property (p_unsup) else $error("unknown id not released");
    property p_done;
        busy && (fam_r == 2'h1 && secure_nonvolatile_memory_done || fam_r == 2'h2 && sig_done || fam_r == 2'h3 && iap_done) |=> !busy;
    endproperty
    a_done: assert property (p_done) else $error("busy kept after done");
    property p_hold;
        busy && (fam_r == 2'h1 && !secure_nonvolatile_memory_done || fam_r == 2'h3 && !iap_done) |=> busy;
    endproperty
    a_hold: assert property (p_hold) else $error("busy dropped early");
    property p_tmo;
        $rose(sig_timeout) |-> $fell(busy);
    endproperty
    a_tmo: assert property (p_tmo) else $error("cap flag without busy release");
endmodule // ssrd_decoder_monitor

bind ssrd_decoder ssrd_decoder_monitor u_mon (.clk(clk), .nrst(nrst), .ss_req(ss_req), .ss_id(ss_id),
    .busy(busy), .unsupported(unsupported), .secure_nonvolatile_memory_start(secure_nonvolatile_memory_start), .secure_nonvolatile_memory_auth(secure_nonvolatile_memory_auth),
    .secure_nonvolatile_memory_cipher(secure_nonvolatile_memory_cipher), .secure_nonvolatile_memory_done(secure_nonvolatile_memory_done), .sig_start(sig_start), .sig_der(sig_der),
    .sig_done(sig_done), .sig_timeout(sig_timeout), .iap_start(iap_start), .iap_verify(iap_verify),
    .iap_by_addr(iap_by_addr), .iap_done(iap_done));

// [test/ssrd_decoder_tb.sv]
// Purpose: self-checking bench for the request decoder
// Assumes: engine model answers after 3 cycles; times cut to 4 cycles per ms
// Notes: signature cap is 5 ms (20 cycles), typical mark 3 ms (12 cycles)
`timescale 1ns/1ps

module ssrd_decoder_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ss_req = 1'b0;
    logic [7:0] ss_id = 8'h00;
    logic hang = 1'b0;
    logic busy, unsup, s_st, s_au, s_ci, s_dn, g_st, g_der, g_dn, g_to, g_ot, i_st, i_ver, i_adr, i_dn;
    int err_total = 0;
    int num_checks = 0;
    int n_sn = 0, n_sg = 0, n_ia = 0;

    initial forever #12.5 clk = ~clk;
    // count start pulses so each request is judged by the family it hit
    always @(posedge clk)
    begin
        n_sn += s_st;
        n_sg += g_st;
        n_ia += i_st;
    end

    ssrd_decoder #(.CYC_PER_MS(4), .SIG_TYP_MS(3), .SIG_MAX_MS(5)) uut (.clk(clk), .nrst(nrst), .ss_req(ss_req),
        .ss_id(ss_id), .busy(busy), .unsupported(unsup), .secure_nonvolatile_memory_start(s_st), .secure_nonvolatile_memory_auth(s_au), .secure_nonvolatile_memory_cipher(s_ci),
        .secure_nonvolatile_memory_done(s_dn), .sig_start(g_st), .sig_der(g_der), .sig_done(g_dn), .sig_timeout(g_to),
        .sig_over_typ(g_ot), .iap_start(i_st), .iap_verify(i_ver), .iap_by_addr(i_adr), .iap_done(i_dn));
    ssrd_engine_model u_eng (.clk(clk), .hang(hang), .secure_nonvolatile_memory_start(s_st), .sig_start(g_st), .iap_start(i_st),
        .secure_nonvolatile_memory_done(s_dn), .sig_done(g_dn), .iap_done(i_dn));

    task tick;
        @(posedge clk);
        #1;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // raise a request, hold id and request until busy drops, count busy cycles
    task automatic req(input logic [7:0] id, output int n);
        int k;
        ss_id = id;
        ss_req = 1'b1;
        n = 0;
        for (k = 0; k < 50 && busy !== 1'b1; k++)
            tick;
        while (busy === 1'b1 && n < 100)
        begin
            tick;
            n++;
        end
        chk(k < 50 && n < 100, 1);
        ss_req = 1'b0;
        tick;
        tick;
    endtask

    task t_reset;
        chk({busy, unsup, s_st, g_st, i_st, g_to, g_ot}, 7'h00);
        $display("test reset done");
    endtask

    task automatic t_timeout;
        int n;
        hang = 1'b1;
        req(8'h19, n);
        hang = 1'b0;
        chk({g_to, g_ot}, 2'h3);
        chk(n >= 20 && n <= 36, 1);
        $display("test timeout done");
    endtask

    task automatic t_ids;
        logic [7:0] ids [13] = '{8'h10, 8'h11, 8'h12, 8'h19, 8'h1a, 8'h42, 8'h43, 8'h44, 8'h45,
            8'h07, 8'h00, 8'h18, 8'h46};
        logic [7:0] id;
        logic sn, sg, ia;
        int n, s0, g0, i0;
        for (int k = 0; k < 13; k++)
        begin
            id = ids[k];
            sn = id >= 8'h10 && id <= 8'h12;
            sg = id == 8'h19 || id == 8'h1a;
            ia = id >= 8'h42 && id <= 8'h45;
            s0 = n_sn;
            g0 = n_sg;
            i0 = n_ia;
            req(id, n);
            chk(unsup, !(sn | sg | ia));
            chk(n_sn - s0 + 2 * (n_sg - g0) + 4 * (n_ia - i0), sn + 2 * sg + 4 * ia);
            chk({g_to, g_ot}, 2'h0);
            chk(sn | sg | ia ? n > 3 : n == 1, 1);
            if (sn)
                chk({s_au, s_ci}, {id != 8'h10, id == 8'h12});
            if (sg)
                chk(g_der, id == 8'h1a);
            if (ia)
                chk({i_ver, i_adr}, {id > 8'h43, id[0]});
        end
        $display("test ids done");
    endtask

    // a hang costs one mismatch and still ends the run in one place
    initial
    begin
        #100000;
        err_total++;
        stop_test;
    end

    initial
    begin
        repeat (16) tick;
        nrst = 1'b1;
        tick;
        t_reset;
        t_timeout;
        t_ids;
        stop_test;
    end
endmodule // ssrd_decoder_tb
